// >>> inc/gpr_pkg.sv
// Shared constants for the GPIO port and pin remap block
package gpr_pkg;
  localparam int ADDR_W = 8;
  localparam int RMP_W = 3;
  localparam logic [7:0] OFS_PA_LAT = 8'h00;
  localparam logic [7:0] OFS_PA_DIR = 8'h04;
  localparam logic [7:0] OFS_PA_WAKE = 8'h08;
  localparam logic [7:0] OFS_PB_LAT = 8'h0C;
  localparam logic [7:0] OFS_PB_DIR = 8'h10;
  localparam logic [7:0] OFS_PC_LAT = 8'h14;
  localparam logic [7:0] OFS_PC_DIR = 8'h18;
  localparam logic [7:0] OFS_REMAP = 8'h1C;
  localparam logic [7:0] PA_MASK = 8'hFF;
  localparam logic [7:0] PB_MASK = 8'h3F;
  localparam logic [7:0] PC_MASK_WIDE = 8'hFF;
  localparam logic [7:0] PC_MASK_NARROW = 8'h0F;
  localparam logic [7:0] RMP_MASK = 8'h07;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] LAT_RST = 8'hFF;
  localparam logic [7:0] WAKE_RST = 8'h00;
  localparam logic [7:0] RMP_RST = 8'h00;
  localparam logic [23:0] RD_PAD = 24'h000000;
  // Remap control bits
  localparam int RMP_CKPS = 0;
  localparam int RMP_SPS = 1;
  localparam int RMP_TBR = 2;
  // Pin positions of the shared functions
  localparam int TB0_DEF_PIN = 0;
  localparam int TB1_DEF_PIN = 1;
  localparam int TB0_ALT_PIN = 6;
  localparam int TB1_ALT_PIN = 7;
  localparam int SDO_DEF_PIN = 5;
  localparam int SDI_DEF_PIN = 6;
  localparam int SCK_DEF_PIN = 7;
  localparam int SCS_DEF_PIN = 4;
  localparam int SDO_ALT_PIN = 1;
  localparam int SDI_ALT_PIN = 0;
  localparam int SCK_ALT_PIN = 7;
  localparam int SCS_ALT_PIN = 6;
  localparam int CKO_DEF_PIN = 2;
  localparam int IRQ_DEF_PIN = 3;
  localparam int CKO_ALT_PIN = 5;
  localparam int IRQ_ALT_PIN = 4;
  localparam int PA_PLAIN_PIN = 3;
endpackage : gpr_pkg

// >>> inc/gpr_mux_if.sv
// Signals shared between the port core, the remap and the wake logic
`timescale 1ns/100ps

interface gpr_mux_if;
  logic [2:0] remap;
  logic [7:0] pa_in;
  logic [7:0] pc_in;
  logic [7:0] pa_wake_en;
  logic low_power;
  logic wake_req;
  logic tmr0, tmr1, tmr_en;
  logic serial_data_out, sck, serial_chip_select, ser_en;
  logic ckout, ckout_en;
  logic [7:0] pa_fn_en, pa_fn_val, pc_fn_en, pc_fn_val;
  logic serial_data_in, irq;
  modport core(output remap, pa_in, pc_in, pa_wake_en, low_power, tmr0, tmr1, tmr_en,
    serial_data_out, sck, serial_chip_select, ser_en, ckout, ckout_en,
    input wake_req, pa_fn_en, pa_fn_val, pc_fn_en, pc_fn_val, serial_data_in, irq);
  modport route(input remap, pa_in, pc_in, tmr0, tmr1, tmr_en, serial_data_out, sck, serial_chip_select, ser_en,
    ckout, ckout_en, output pa_fn_en, pa_fn_val, pc_fn_en, pc_fn_val, serial_data_in, irq);
  modport wake(input pa_in, pa_wake_en, low_power, output wake_req);
endinterface : gpr_mux_if

// >>> src/gpr_wake.sv
// Port A falling-edge wake detector
`timescale 1ns/100ps

module gpr_wake
  import gpr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  gpr_mux_if.wake m
);
  typedef struct packed {
    logic [7:0] prev;
    logic wake;
  } gpr_wake_state_t;

  gpr_wake_state_t s_reg;
  gpr_wake_state_t s_next;
  logic [7:0] fall;

  // R17 registered high then low
  assign fall = s_reg.prev & ~m.pa_in & m.pa_wake_en;

  always_comb begin
    s_next = s_reg;
    s_next.prev = m.pa_in & m.pa_wake_en;
    // R9 R10 any enabled pin wakes
    s_next.wake = m.low_power && (|fall);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign m.wake_req = s_reg.wake;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  wake_fall_a: assert property ((ce_i && m.low_power && (|fall)) |=> m.wake_req) // R9
    else $error("falling enabled pin gave no wake");
  wake_awake_a: assert property ((ce_i && !m.low_power) |=> !m.wake_req) // R9
    else $error("wake raised outside low-power mode");
  wake_single_a: assert property ((ce_i && m.wake_req) ##1 (ce_i && $stable(m.pa_in)) |=> !m.wake_req) // R17
    else $error("wake request repeated without new edge");
  wake_seen_c: cover property (ce_i && m.wake_req);
endmodule : gpr_wake

// >>> src/gpr_remap.sv
// Pin remap of timer, serial, clock-out and interrupt functions
`timescale 1ns/100ps

module gpr_remap
  import gpr_pkg::*;
(
  gpr_mux_if.route m
);
  always_comb begin
    m.pa_fn_en = '0;
    m.pa_fn_val = '0;
    m.pc_fn_en = '0;
    m.pc_fn_val = '0;
    // R13 timer outputs
    if (m.remap[RMP_TBR] && m.remap[RMP_SPS]) begin
      m.pa_fn_en[TB0_ALT_PIN] = m.tmr_en;
      m.pa_fn_val[TB0_ALT_PIN] = m.tmr0;
      m.pa_fn_en[TB1_ALT_PIN] = m.tmr_en;
      m.pa_fn_val[TB1_ALT_PIN] = m.tmr1;
    end else begin
      m.pc_fn_en[TB0_DEF_PIN] = m.tmr_en;
      m.pc_fn_val[TB0_DEF_PIN] = m.tmr0;
      m.pc_fn_en[TB1_DEF_PIN] = m.tmr_en;
      m.pc_fn_val[TB1_DEF_PIN] = m.tmr1;
    end
    // R14 serial pins, over the timer
    if (m.ser_en && m.remap[RMP_SPS]) begin
      m.pc_fn_en[SDO_ALT_PIN] = 1'b1;
      m.pc_fn_val[SDO_ALT_PIN] = m.serial_data_out;
      m.pc_fn_en[SCK_ALT_PIN] = 1'b1;
      m.pc_fn_val[SCK_ALT_PIN] = m.sck;
      m.pc_fn_en[SCS_ALT_PIN] = 1'b1;
      m.pc_fn_val[SCS_ALT_PIN] = m.serial_chip_select;
    end else if (m.ser_en) begin
      m.pa_fn_en[SDO_DEF_PIN] = 1'b1;
      m.pa_fn_val[SDO_DEF_PIN] = m.serial_data_out;
      m.pa_fn_en[SCK_DEF_PIN] = 1'b1;
      m.pa_fn_val[SCK_DEF_PIN] = m.sck;
      m.pa_fn_en[SCS_DEF_PIN] = 1'b1;
      m.pa_fn_val[SCS_DEF_PIN] = m.serial_chip_select;
    end
    // R15 clock out position
    if (m.remap[RMP_CKPS]) begin
      m.pc_fn_en[CKO_ALT_PIN] = m.ckout_en;
      m.pc_fn_val[CKO_ALT_PIN] = m.ckout;
    end else begin
      m.pc_fn_en[CKO_DEF_PIN] = m.ckout_en;
      m.pc_fn_val[CKO_DEF_PIN] = m.ckout;
    end
  end

  // R14 serial data in source
  assign m.serial_data_in = m.remap[RMP_SPS] ? m.pc_in[SDI_ALT_PIN] : m.pa_in[SDI_DEF_PIN];
  // R15 interrupt input source
  assign m.irq = m.remap[RMP_CKPS] ? m.pc_in[IRQ_ALT_PIN] : m.pc_in[IRQ_DEF_PIN];
endmodule : gpr_remap

// >>> src/gpr_top.sv
// GPIO ports A to C: APB registers, pin sync, drive, read-back and wake
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps

// How it works
// R1 - Direction bit one makes the pin an input and releases its driver.
// R2 - Direction bit zero drives the pin push-pull from its data latch.
// R3 - Reading an input pin returns its sampled level.
// R4 - Reading an output pin returns its latch, not the pin level.
// R5 - Reset sets every implemented direction and latch bit to one.
// R6 - Direction bits without a pin ignore writes and read zero.
// R7 - A pin turned output before a latch write drives high.
// R8 - Bit set or clear is read, modify, write back of the whole byte.
// R9 - In sleep or idle an enabled port A falling edge wakes the device.
// R10 - Any single port A pin or any combination may wake.
// R11 - Per-pin wake enable, one enables, all reset to zero.
// R12 - Latches keep their value until software writes them again.
// R13 - Remap bit 2 moves timer outputs to port A 6 and 7 when serial select set.
// R14 - Remap bit 1 picks port C or port A placement of serial pins.
// R15 - Remap bit 0 moves clock out and interrupt in to port C 5 and 4.
// R16 - Remap bits 7 to 3 ignore writes and read zero.
// R17 - Wake detector registers enabled pins, one request per high then low.
module gpr_top
  import gpr_pkg::*;
#(
  parameter bit PC_WIDE = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [7:0] pa_pin_i,
  output logic [7:0] pa_pin_o,
  output logic [7:0] pa_oe_b_o,
  input wire logic [7:0] pb_pin_i,
  output logic [7:0] pb_pin_o,
  output logic [7:0] pb_oe_b_o,
  input wire logic [7:0] pc_pin_i,
  output logic [7:0] pc_pin_o,
  output logic [7:0] pc_oe_b_o,
  input wire logic low_power_i,
  output logic wake_o,
  input wire logic timer1_b_out0_i,
  input wire logic timer1_b_out1_i,
  input wire logic timer1_b_en_i,
  input wire logic serial_data_out_i,
  input wire logic serial_clk_i,
  input wire logic serial_chip_select_i,
  input wire logic serial_en_i,
  input wire logic peripheral_clock_out_i,
  input wire logic clkout_en_i,
  output logic serial_data_in_o,
  output logic peripheral_irq_in_o
);
  localparam logic [7:0] PC_MASK = PC_WIDE ? PC_MASK_WIDE : PC_MASK_NARROW;
  localparam logic [7:0] RM_MASK = PC_WIDE ? RMP_MASK : 8'h00;

  typedef struct packed {
    logic [7:0] pa_s1, pa_s2, pb_s1, pb_s2, pc_s1, pc_s2;
    logic [7:0] pa_dir, pb_dir, pc_dir;
    logic [7:0] pa_lat, pb_lat, pc_lat;
    logic [7:0] pa_wake, remap;
    logic [7:0] pa_out, pb_out, pc_out;
    logic [7:0] pa_oe_b, pb_oe_b, pc_oe_b;
    logic [7:0] rdata;
    logic armed, slverr, serial_data_in, irq;
  } gpr_top_state_t;

  // R5 all pins start as inputs
  localparam gpr_top_state_t ST_RST = '{
    pa_dir: DIR_RST & PA_MASK, pb_dir: DIR_RST & PB_MASK, pc_dir: DIR_RST & PC_MASK,
    pa_lat: LAT_RST & PA_MASK, pb_lat: LAT_RST & PB_MASK, pc_lat: LAT_RST & PC_MASK,
    pa_out: LAT_RST & PA_MASK, pb_out: LAT_RST & PB_MASK, pc_out: LAT_RST & PC_MASK,
    pa_oe_b: DIR_RST, pb_oe_b: DIR_RST, pc_oe_b: DIR_RST,
    pa_wake: WAKE_RST, remap: RMP_RST, default: '0};

  gpr_top_state_t s_reg;
  gpr_top_state_t s_next;
  gpr_mux_if m();
  logic cap;
  logic acc;
  logic acc_wr;
  logic [7:0] wb;
  logic [7:0] rd_pa;
  logic [7:0] rd_pb;
  logic [7:0] rd_pc;

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  assign cap = psel_i && !s_reg.armed;
  assign pready_o = s_reg.armed && ce_i;
  assign acc = psel_i && penable_i && pready_o;
  assign acc_wr = acc && pwrite_i && pstrb_i[0];
  assign wb = pwdata_i[7:0];

  // R3 R4 pin or latch per bit
  assign rd_pa = (s_reg.pa_dir & s_reg.pa_s2) | (~s_reg.pa_dir & s_reg.pa_lat);
  assign rd_pb = (s_reg.pb_dir & s_reg.pb_s2) | (~s_reg.pb_dir & s_reg.pb_lat);
  assign rd_pc = (s_reg.pc_dir & s_reg.pc_s2) | (~s_reg.pc_dir & s_reg.pc_lat);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.pa_s1 = pa_pin_i;
    s_next.pa_s2 = s_reg.pa_s1;
    s_next.pb_s1 = pb_pin_i;
    s_next.pb_s2 = s_reg.pb_s1;
    s_next.pc_s1 = pc_pin_i;
    s_next.pc_s2 = s_reg.pc_s1;
    if (cap) begin
      s_next.armed = 1'b1;
    end else if (acc) begin
      s_next.armed = 1'b0;
    end
    // R8 whole byte written back
    if (acc_wr) begin
      if (paddr_i == OFS_PA_LAT) begin
        s_next.pa_lat = wb & PA_MASK;
      end else if (paddr_i == OFS_PA_DIR) begin
        s_next.pa_dir = wb & PA_MASK;
      end else if (paddr_i == OFS_PA_WAKE) begin
        // R11 R10 per-pin wake enables
        s_next.pa_wake = wb;
      end else if (paddr_i == OFS_PB_LAT) begin
        s_next.pb_lat = wb & PB_MASK;
      end else if (paddr_i == OFS_PB_DIR) begin
        // R6 missing pins stay zero
        s_next.pb_dir = wb & PB_MASK;
      end else if (paddr_i == OFS_PC_LAT) begin
        s_next.pc_lat = wb & PC_MASK;
      end else if (paddr_i == OFS_PC_DIR) begin
        s_next.pc_dir = wb & PC_MASK;
      end else if (paddr_i == OFS_REMAP) begin
        // R16 upper bits unimplemented
        s_next.remap = wb & RM_MASK;
      end
    end
    if (cap) begin
      s_next.slverr = 1'b0;
      if (paddr_i == OFS_PA_LAT) begin
        s_next.rdata = rd_pa;
      end else if (paddr_i == OFS_PA_DIR) begin
        s_next.rdata = s_reg.pa_dir;
      end else if (paddr_i == OFS_PA_WAKE) begin
        s_next.rdata = s_reg.pa_wake;
      end else if (paddr_i == OFS_PB_LAT) begin
        s_next.rdata = rd_pb;
      end else if (paddr_i == OFS_PB_DIR) begin
        s_next.rdata = s_reg.pb_dir;
      end else if (paddr_i == OFS_PC_LAT) begin
        s_next.rdata = rd_pc;
      end else if (paddr_i == OFS_PC_DIR) begin
        s_next.rdata = s_reg.pc_dir;
      end else if (paddr_i == OFS_REMAP) begin
        s_next.rdata = s_reg.remap;
      end else begin
        s_next.rdata = '0;
        s_next.slverr = 1'b1;
      end
    end
    // R2 R7 drive from latch or function
    s_next.pa_out = ((m.pa_fn_en & m.pa_fn_val) | (~m.pa_fn_en & s_reg.pa_lat)) & PA_MASK;
    s_next.pb_out = s_reg.pb_lat & PB_MASK;
    s_next.pc_out = ((m.pc_fn_en & m.pc_fn_val) | (~m.pc_fn_en & s_reg.pc_lat)) & PC_MASK;
    // R1 input releases driver
    s_next.pa_oe_b = s_reg.pa_dir | ~PA_MASK;
    s_next.pb_oe_b = s_reg.pb_dir | ~PB_MASK;
    s_next.pc_oe_b = s_reg.pc_dir | ~PC_MASK;
    s_next.serial_data_in = m.serial_data_in;
    s_next.irq = m.irq;
  end

  // R12 latches change only on write
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg <= ST_RST;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Sub-blocks
  // ----------------------------------------
  assign m.remap = s_reg.remap[RMP_W-1:0];
  assign m.pa_in = s_reg.pa_s2;
  assign m.pc_in = s_reg.pc_s2;
  assign m.pa_wake_en = s_reg.pa_wake;
  assign m.low_power = low_power_i;
  assign m.tmr0 = timer1_b_out0_i;
  assign m.tmr1 = timer1_b_out1_i;
  assign m.tmr_en = timer1_b_en_i;
  assign m.serial_data_out = serial_data_out_i;
  assign m.sck = serial_clk_i;
  assign m.serial_chip_select = serial_chip_select_i;
  assign m.ser_en = serial_en_i;
  assign m.ckout = peripheral_clock_out_i;
  assign m.ckout_en = clkout_en_i;

  gpr_remap u_remap (
    .m(m.route)
  );

  gpr_wake u_wake (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .m(m.wake)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata_o = {RD_PAD, s_reg.rdata};
  assign pslverr_o = s_reg.slverr;
  assign pa_pin_o = s_reg.pa_out;
  assign pb_pin_o = s_reg.pb_out;
  assign pc_pin_o = s_reg.pc_out;
  assign pa_oe_b_o = s_reg.pa_oe_b;
  assign pb_oe_b_o = s_reg.pb_oe_b;
  assign pc_oe_b_o = s_reg.pc_oe_b;
  assign wake_o = m.wake_req;
  assign serial_data_in_o = s_reg.serial_data_in;
  assign peripheral_irq_in_o = s_reg.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  dir_release_a: assert property ((acc_wr && paddr_i == OFS_PA_DIR) ##1 ce_i
    |=> pa_oe_b_o == $past(wb, 2)) // R1
    else $error("direction write not seen on driver enables");
  out_latch_a: assert property ((ce_i && $stable(s_reg.pb_lat)) |=> pb_pin_o == $past(s_reg.pb_lat)) // R2
    else $error("driven pin does not follow its latch");
  rd_input_a: assert property ((ce_i && cap && paddr_i == OFS_PA_LAT)
    |=> (prdata_o[7:0] & $past(s_reg.pa_dir)) == ($past(s_reg.pa_s2) & $past(s_reg.pa_dir))) // R3
    else $error("input bit read is not the pin level");
  rd_latch_a: assert property ((ce_i && cap && paddr_i == OFS_PA_LAT)
    |=> (prdata_o[7:0] & ~$past(s_reg.pa_dir)) == ($past(s_reg.pa_lat) & ~$past(s_reg.pa_dir))) // R4
    else $error("output bit read is not the latch");
  rst_ones_a: assert property (@(posedge clk_i) $rose(rst_b_i)
    |-> (s_reg.pa_dir == DIR_RST && s_reg.pa_lat == LAT_RST && pa_oe_b_o == DIR_RST)) // R5
    else $error("reset did not set direction and latch");
  unimpl_zero_a: assert property ((s_reg.pb_dir & ~PB_MASK) == '0 && (s_reg.pc_dir & ~PC_MASK) == '0) // R6
    else $error("unimplemented direction bit set");
  first_high_a: assert property ((ce_i && $fell(s_reg.pa_dir[PA_PLAIN_PIN]) && s_reg.pa_lat[PA_PLAIN_PIN])
    |=> (pa_pin_o[PA_PLAIN_PIN] && !pa_oe_b_o[PA_PLAIN_PIN])) // R7
    else $error("new output did not drive high");
  latch_hold_a: assert property (!(acc_wr && paddr_i == OFS_PA_LAT) |=> $stable(s_reg.pa_lat)) // R12
    else $error("latch changed without a write");
  remap_zero_a: assert property ((s_reg.remap & ~RMP_MASK) == '0) // R16
    else $error("unimplemented remap bit set");
  tmr_move_a: assert property ((m.remap[RMP_TBR] && m.remap[RMP_SPS] && timer1_b_en_i)
    |-> (m.pa_fn_en[TB0_ALT_PIN] && m.pa_fn_val[TB1_ALT_PIN] == timer1_b_out1_i)) // R13
    else $error("timer output not moved to port A");
  sdi_route_a: assert property ((ce_i && m.remap[RMP_SPS])
    |=> serial_data_in_o == $past(s_reg.pc_s2[SDI_ALT_PIN])) // R14
    else $error("serial data in not taken from port C");
  ckout_move_a: assert property ((m.remap[RMP_CKPS] && clkout_en_i)
    |-> (m.pc_fn_en[CKO_ALT_PIN] && !m.pc_fn_en[CKO_DEF_PIN])) // R15
    else $error("clock out not moved");
  wake_rd_a: assert property ((ce_i && cap && paddr_i == OFS_PA_WAKE)
    |=> prdata_o[7:0] == $past(s_reg.pa_wake)) // R11
    else $error("wake enable read differs from register");
  pb_rd_a: assert property ((ce_i && cap && paddr_i == OFS_PB_LAT)
    |=> (prdata_o[7:0] & $past(s_reg.pb_dir)) == ($past(s_reg.pb_s2) & $past(s_reg.pb_dir))) // R3
    else $error("port B input bit read is not the pin level");
  pb_release_a: assert property (ce_i
    |=> pb_oe_b_o == ($past(s_reg.pb_dir) | ~PB_MASK)) // R1
    else $error("port B driver enables do not follow direction");
  lat_write_a: assert property ((acc_wr && paddr_i == OFS_PA_LAT)
    |=> s_reg.pa_lat == $past(wb)) // R2
    else $error("port A latch write did not land");
  pc_hold_a: assert property (!(acc_wr && paddr_i == OFS_PC_LAT) |=> $stable(s_reg.pc_lat)) // R12
    else $error("port C latch changed without a write");
  irq_route_a: assert property ((ce_i && m.remap[RMP_CKPS])
    |=> peripheral_irq_in_o == $past(s_reg.pc_s2[IRQ_ALT_PIN])) // R15
    else $error("interrupt input not taken from moved pin");
  tmr_home_a: assert property ((!m.remap[RMP_TBR] && timer1_b_en_i && !serial_en_i)
    |-> (m.pc_fn_en[TB1_DEF_PIN] && m.pc_fn_val[TB0_DEF_PIN] == timer1_b_out0_i)) // R13
    else $error("timer output left its home pin");
  map_err_a: assert property ((ce_i && cap && paddr_i > OFS_REMAP)
    |=> (pslverr_o && prdata_o == '0)) // R6
    else $error("unmapped address gave no error");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  rd_input_c: cover property (acc && !pwrite_i && paddr_i == OFS_PA_LAT && s_reg.pa_dir != '0);
  drive_out_c: cover property (pa_oe_b_o != DIR_RST);
  remap_wr_c: cover property (acc_wr && paddr_i == OFS_REMAP);
  err_seen_c: cover property (acc && s_reg.slverr);
endmodule : gpr_top

// >>> tb/gpr_pin_model.sv
// Board circuitry seen by one 8-bit port
`timescale 1ns/100ps

module gpr_pin_model (
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_b_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] lvl_o
);
  // ---------------------------------------------
  // Wire level
  // ---------------------------------------------
  // released or driven
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      lvl_o[i] = oe_b_i[i] ? ext_i[i] : drv_i[i];
    end
  end
endmodule : gpr_pin_model

// >>> tb/gpr_top_tb.sv
// Self-checking bench for the GPIO port and pin remap block
`timescale 1ns/100ps

module gpr_top_tb;
  import gpr_pkg::*;
  logic clk_i, rst_b_i, ce_i, psel_i, penable_i, pwrite_i, low_power_i, pready_o, pslverr_o, wake_o, sdi_o, irq_o;
  logic [ADDR_W-1:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic [3:0] pstrb_i;
  logic [7:0] pa_i, pa_o, pa_oe, pb_i, pb_o, pb_oe, pc_i, pc_o, pc_oe, ext_a, ext_b, ext_c;
  logic [7:0] rv, v, la, lc, ea, ec;
  logic [5:0] fn;
  logic [2:0] fen;
  logic [33:0] expq[$];
  logic [33:0] e;
  int bad_count, n_compared, cyc, wake_cnt;

  gpr_top u_gpr_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .pa_pin_i(pa_i), .pa_pin_o(pa_o), .pa_oe_b_o(pa_oe),
    .pb_pin_i(pb_i), .pb_pin_o(pb_o), .pb_oe_b_o(pb_oe), .pc_pin_i(pc_i), .pc_pin_o(pc_o), .pc_oe_b_o(pc_oe),
    .low_power_i(low_power_i), .wake_o(wake_o), .timer1_b_out0_i(fn[0]), .timer1_b_out1_i(fn[1]),
    .timer1_b_en_i(fen[0]), .serial_data_out_i(fn[2]), .serial_clk_i(fn[3]), .serial_chip_select_i(fn[4]),
    .serial_en_i(fen[1]), .peripheral_clock_out_i(fn[5]), .clkout_en_i(fen[2]),
    .serial_data_in_o(sdi_o), .peripheral_irq_in_o(irq_o));
  gpr_pin_model u_gpr_pin_model_a (.drv_i(pa_o), .oe_b_i(pa_oe), .ext_i(ext_a), .lvl_o(pa_i));
  gpr_pin_model u_gpr_pin_model_b (.drv_i(pb_o), .oe_b_i(pb_oe), .ext_i(ext_b), .lvl_o(pb_i));
  gpr_pin_model u_gpr_pin_model_c (.drv_i(pc_o), .oe_b_i(pc_oe), .ext_i(ext_c), .lvl_o(pc_i));

  // ---------------------------------------------
  // Clock, timeout, monitors
  // ---------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      $display("ERROR timeout after %0d cycles", cyc);
      summarize();
    end
  end

  always @(negedge clk_i) begin
    if (wake_o === 1'b1) wake_cnt++;
    if (psel_i && penable_i && pready_o === 1'b1) begin
      if (expq.size() == 0) begin
        bad_count++;
        $display("ERROR unexpected transfer");
      end else begin
        e = expq.pop_front();
        chk("pslverr", 32'(pslverr_o), 32'(e[32]));
        if (e[33]) chk("prdata", prdata_o, e[31:0]);
      end
    end
  end

  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, input logic [33:0] x);
    expq.push_back(x);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h000000, d};
    pstrb_i <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rv = prdata_o[7:0];
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hF, 34'h000000000);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00, 4'hF, {2'b10, 24'h000000, exp});
  endtask : rd

  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task wake_try(input logic [7:0] lvl, input int exp);
    ext_a <= 8'hFF;
    tick(4);
    wake_cnt = 0;
    ext_a <= lvl;
    tick(6);
    chk("wake pulses", 32'(wake_cnt), 32'(exp));
  endtask : wake_try

  task summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h00000000;
    pstrb_i = 4'h0;
    low_power_i = 1'b0;
    fn = 6'h00;
    fen = 3'h0;
    ext_a = 8'hFF;
    ext_c = 8'hFF;
    cyc = 0;
    bad_count = 0;
    n_compared = 0;
    wake_cnt = 0;
    v = 8'($urandom(62680));
    ext_b = 8'($urandom);
    tick(20);
    rst_b_i <= 1'b1;
    tick(1);
    chk("pa_oe", 32'(pa_oe), 32'hFF);
    chk("pb_oe", 32'(pb_oe), 32'hFF);
    chk("pc_oe", 32'(pc_oe), 32'hFF);
    chk("pb_o", 32'(pb_o), 32'h3F);
    rd(OFS_PA_DIR, 8'hFF);
    rd(OFS_PB_DIR, 8'h3F);
    rd(OFS_PC_DIR, 8'hFF);
    rd(OFS_PA_WAKE, 8'h00);
    rd(OFS_REMAP, 8'h00);
    $display("test reset done");
    wr(OFS_PB_DIR, 8'h00);
    tick(3);
    chk("pb_oe", 32'(pb_oe), 32'hC0);
    wr(OFS_PB_DIR, 8'hFF);
    rd(OFS_PB_DIR, 8'h3F);
    rd(OFS_PB_LAT, ext_b & 8'h3F);
    wr(OFS_REMAP, 8'hFF);
    rd(OFS_REMAP, 8'h07);
    apb(1'b0, 8'h20, 8'h00, 4'hF, {2'b11, 32'h00000000});
    apb(1'b1, OFS_PA_DIR, 8'h00, 4'h0, 34'h000000000);
    ce_i <= 1'b0;
    fork
      begin
        tick(3);
        ce_i <= 1'b1;
      end
    join_none
    rd(OFS_PA_DIR, 8'hFF);
    $display("test masks done");
    ext_a <= ~v;
    wr(OFS_PA_DIR, 8'h00);
    tick(3);
    chk("pa_o", 32'(pa_o), 32'hFF);
    chk("pa_oe", 32'(pa_oe), 32'h00);
    wr(OFS_PA_LAT, v);
    tick(3);
    chk("pa_o", 32'(pa_o), 32'(v));
    rd(OFS_PA_LAT, v);
    tick(20);
    rd(OFS_PA_LAT, v);
    wr(OFS_PA_DIR, 8'h0F);
    ext_a <= 8'($urandom);
    tick(4);
    chk("pa_oe", 32'(pa_oe), 32'h0F);
    rd(OFS_PA_LAT, {v[7:4], ext_a[3:0]});
    rd(OFS_PC_DIR, 8'hFF);
    wr(OFS_PC_DIR, rv & 8'hF7);
    rd(OFS_PC_DIR, 8'hF7);
    $display("test direction done");
    wr(OFS_PA_DIR, 8'hFF);
    wr(OFS_PA_WAKE, 8'h05);
    low_power_i <= 1'b1;
    wake_try(8'hFB, 1);
    wake_try(8'hFA, 1);
    wake_try(8'hFD, 0);
    wake_try(8'hFB, 1);
    wake_try(8'hFF, 0);
    low_power_i <= 1'b0;
    wake_try(8'hFE, 0);
    $display("test wake done");
    fen <= 3'h7;
    wr(OFS_PA_DIR, 8'h00);
    wr(OFS_PC_DIR, 8'h00);
    for (int rm = 0; rm < 8; rm++) begin
      la = 8'($urandom);
      lc = 8'($urandom);
      fn <= 6'($urandom);
      wr(OFS_PA_LAT, la);
      wr(OFS_PC_LAT, lc);
      wr(OFS_REMAP, 8'(rm));
      tick(6);
      ea = la;
      ec = lc;
      if (rm[0]) ec[5] = fn[5];
      else ec[2] = fn[5];
      if (rm[2] && rm[1]) ea[7:6] = fn[1:0];
      else ec[1:0] = fn[1:0];
      if (rm[1]) {ec[7:6], ec[1]} = {fn[3], fn[4], fn[2]};
      else {ea[7], ea[5:4]} = {fn[3], fn[2], fn[4]};
      chk("pa_o", 32'(pa_o), 32'(ea));
      chk("pc_o", 32'(pc_o), 32'(ec));
      chk("sdi", 32'(sdi_o), 32'(rm[1] ? ec[0] : ea[6]));
      chk("irq", 32'(irq_o), 32'(rm[0] ? ec[4] : ec[3]));
    end
    chk("pc_oe", 32'(pc_oe), 32'h00);
    fen <= 3'h0;
    tick(4);
    chk("pa_o", 32'(pa_o), 32'(la));
    chk("pc_o", 32'(pc_o), 32'(lc));
    $display("test remap done");
    summarize();
  end
endmodule : gpr_top_tb
